// ===== rtl/xbi_pkg.sv
package xbi_pkg;

	// ==========================================================
	// Register map, word indices on the register port
	localparam logic [3:0] REG_BANK_CTRL = 4'h0;
	localparam logic [3:0] REG_CPU_CTRL = 4'h1;
	localparam logic [3:0] REG_IRQ_MASK = 4'h2;
	localparam logic [3:0] REG_IRQ_PEND = 4'h3;
	localparam logic [3:0] REG_EVT_STAT = 4'h4;
	localparam logic [3:0] REG_EVT_MASK = 4'h5;
	localparam logic [3:0] REG_BUS_STAT = 4'h6;

	// ==========================================================
	// Field positions and reset values
	localparam int BANK_KEEPER_BIT = 0;
	localparam int CPU_GDIS_BIT = 0;
	localparam int PEND_NMI_BIT = 4;
	localparam int EVT_VECTOR_BIT = 0;
	localparam int EVT_HOLD_BIT = 1;
	localparam int EVT_BOOT_BIT = 2;
	localparam logic KEEPER_RST = 1'b0;
	localparam logic GDIS_RST = 1'b1;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;
	localparam logic [2:0] EVT_MASK_RST = 3'h0;

	// ==========================================================
	// Addresses and vectors
	localparam logic [19:0] START_ADDR = 20'h0FF80;
	localparam logic [15:0] VEC_BASE = 16'hFF80;
	localparam logic [15:0] VEC_STEP = 16'h0004;
	localparam logic [15:0] NMI_VEC_IDX = 16'h0002;
	localparam logic [15:0] USER_VEC_IDX0 = 16'h0010;

	// ==========================================================
	// Types
	typedef enum logic [4:0] {
		ST_RESET = 5'b00001,
		ST_IDLE = 5'b00010,
		ST_ADDR = 5'b00100,
		ST_DATA = 5'b01000,
		ST_HOLD = 5'b10000
	} xbi_state_t;

	typedef enum logic [1:0] {
		KIND_CORE = 2'h0,
		KIND_BOOT = 2'h1,
		KIND_VEC = 2'h2
	} xbi_kind_t;

	typedef struct packed {
		logic write;
		logic prog;
		logic [19:0] addr;
		logic [15:0] wdata;
	} xbi_req_t;

	typedef struct packed {
		xbi_kind_t kind;
		logic [15:0] data;
	} xbi_rsp_t;

	typedef struct packed {
		xbi_state_t st;
		logic [19:0] addr;
		logic [15:0] wdata;
		logic wr;
		xbi_kind_t kind;
		logic keep_en;
		logic gdis;
		logic [3:0] imask;
		logic [3:0] ipend;
		logic nmi_pend;
		logic [2:0] evt;
		logic [2:0] emask;
		logic [15:0] reg_rdata;
		logic rsp_valid;
		xbi_rsp_t rsp;
		logic [3:0] irq_prev;
		logic nmi_prev;
		logic [15:0] last_d;
	} xbi_core_t;

endpackage

// ===== rtl/xbi_sync.sv
`timescale 1ns/10ps
`default_nettype none
module xbi_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RVAL = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// ==========================================================
	// Two-stage synchroniser, stage 0 feeds only stage 1.
	logic [1:0][W-1:0] s_q;
	logic [1:0][W-1:0] s_d;

	always_comb begin
		s_d[0] = d;
		s_d[1] = s_q[0];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= {RVAL, RVAL};
		end else begin
			s_q <= s_d;
		end
	end

	assign q = s_q[1];
endmodule // xbi_sync
`default_nettype wire

// ===== rtl/xbi_irq_pick.sv
`timescale 1ns/10ps
`default_nettype none
module xbi_irq_pick #(
	parameter int N = 4
) (
	input wire logic [N-1:0] req,
	output logic any,
	output logic [1:0] idx
);
	// ==========================================================
	// Lowest set index wins, scanned downward so it is assigned last.
	always_comb begin
		any = |req;
		idx = 2'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = i[1:0];
			end
		end
	end
endmodule // xbi_irq_pick
`default_nettype wire

// ===== rtl/xbi_bus_pins.sv
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Drive 20 address lines; upper four only for program space accesses.
// - Address outputs float during hold or while offline input is low.
// - One shared 16-bit bidirectional data bus carries all external transfers.
// - Data outputs float unless writing, and during reset or hold request.
// - Data outputs also float whenever the offline input is low.
// - Enabled keeper holds each data line at its last level when undriven.
// - Keeper is off after reset and switched by one bank-control bit.
// - Acknowledge output is high during the vector fetch, vector on low lines.
// - Acknowledge output floats while the offline input is low.
// - Four prioritized user interrupts, masked individually and by global disable.
// - Each user interrupt latches a pending flag software can read and clear.
// - Non-maskable interrupt ignores masks and traps to its own vector.
// - Reset input stops execution and reinitializes the registers and status.
// - On reset release the first fetch is from the fixed start address.
// - Hold request releases address and data, not the interrupt acknowledge; release acknowledge shows it.
module xbi_bus_pins
	import xbi_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic RESET_IN_N,
	input wire logic [3:0] USER_IRQ_IN_N,
	input wire logic NMI_IN_N,
	input wire logic HOLD_REQ_N,
	input wire logic OFFLINE_FLOAT_N,
	input wire logic REQ_VALID,
	input wire xbi_pkg::xbi_req_t REQ,
	output logic REQ_READY,
	output logic RSP_VALID,
	output xbi_pkg::xbi_rsp_t RSP,
	input wire logic [3:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [15:0] REG_RDATA,
	output logic IRQ_OUT,
	output logic [19:0] A_OUT,
	output logic A_OE,
	input wire logic [15:0] D_IN,
	output logic [15:0] D_OUT,
	output logic D_OE,
	output logic D_KEEP_EN,
	output logic [15:0] D_KEEP_VAL,
	output logic IRQ_ACK_OUT,
	output logic IRQ_ACK_OE,
	output logic BUS_RELEASE_ACK,
	output logic BUS_RELEASE_ACK_OE
);
	import xbi_pkg::*;

	// ==========================================================
	// Input synchronisers
	logic [3:0] irq_n_s;
	logic nmi_n_s;
	logic rst_n_s;
	logic hold_n_s;

	xbi_sync #(.W(4), .RVAL(4'hF)) u_sync_irq (
		.clk(CLK_SYS),
		.rst(RST),
		.d(USER_IRQ_IN_N),
		.q(irq_n_s)
	);

	xbi_sync #(.W(3), .RVAL(3'h7)) u_sync_ctl (
		.clk(CLK_SYS),
		.rst(RST),
		.d({NMI_IN_N, RESET_IN_N, HOLD_REQ_N}),
		.q({nmi_n_s, rst_n_s, hold_n_s})
	);

	// ==========================================================
	// State
	xbi_core_t c_q;
	xbi_core_t c_d;

	logic [3:0] irq_ready;
	logic irq_any;
	logic [1:0] irq_idx;
	logic hold_req;
	logic offline;
	logic driving;
	logic [15:0] vec_idx;

	assign hold_req = ~hold_n_s;
	assign offline = ~OFFLINE_FLOAT_N;
	assign irq_ready = c_q.ipend & c_q.imask & {4{~c_q.gdis}};

	xbi_irq_pick #(.N(4)) u_pick (
		.req(irq_ready),
		.any(irq_any),
		.idx(irq_idx)
	);

	always_comb begin
		vec_idx = USER_VEC_IDX0 + {14'h0000, irq_idx};
	end

	// ==========================================================
	// Next-state logic
	always_comb begin
		c_d = c_q;
		c_d.rsp_valid = 1'b0;
		c_d.reg_rdata = 16'h0000;
		c_d.irq_prev = irq_n_s;
		c_d.nmi_prev = nmi_n_s;
		c_d.last_d = driving ? c_q.wdata : D_IN;

		// Register-port writes: ones clear pending and event flags, the control and mask registers load.
		if (REG_WR && REG_ADDR == REG_IRQ_PEND) begin
			c_d.ipend = c_q.ipend & ~REG_WDATA[3:0];
			c_d.nmi_pend = c_q.nmi_pend & ~REG_WDATA[PEND_NMI_BIT];
		end
		if (REG_WR && REG_ADDR == REG_EVT_STAT) begin
			c_d.evt = c_q.evt & ~REG_WDATA[2:0];
		end
		if (REG_WR && REG_ADDR == REG_BANK_CTRL) begin
			c_d.keep_en = REG_WDATA[BANK_KEEPER_BIT];
		end
		if (REG_WR && REG_ADDR == REG_CPU_CTRL) begin
			c_d.gdis = REG_WDATA[CPU_GDIS_BIT];
		end
		if (REG_WR && REG_ADDR == REG_IRQ_MASK) begin
			c_d.imask = REG_WDATA[3:0];
		end
		if (REG_WR && REG_ADDR == REG_EVT_MASK) begin
			c_d.emask = REG_WDATA[2:0];
		end

		case (c_q.st)
			ST_RESET: begin
				c_d.st = ST_ADDR;
				c_d.addr = START_ADDR;
				c_d.wr = 1'b0;
				c_d.kind = KIND_BOOT;
			end
			ST_IDLE: begin
				if (hold_req) begin
					c_d.st = ST_HOLD;
					c_d.evt[EVT_HOLD_BIT] = 1'b1;
				end else if (c_q.nmi_pend) begin
					c_d.st = ST_ADDR;
					c_d.addr = {4'h0, VEC_BASE + NMI_VEC_IDX * VEC_STEP};
					c_d.wr = 1'b0;
					c_d.kind = KIND_VEC;
					c_d.nmi_pend = 1'b0;
					c_d.evt[EVT_VECTOR_BIT] = 1'b1;
				end else if (irq_any) begin
					c_d.st = ST_ADDR;
					c_d.addr = {4'h0, VEC_BASE + vec_idx * VEC_STEP};
					c_d.wr = 1'b0;
					c_d.kind = KIND_VEC;
					c_d.gdis = 1'b1;
					c_d.ipend[irq_idx] = 1'b0;
					c_d.evt[EVT_VECTOR_BIT] = 1'b1;
				end else if (REQ_VALID) begin
					c_d.st = ST_ADDR;
					c_d.addr = REQ.prog ? REQ.addr : {4'h0, REQ.addr[15:0]};
					c_d.wdata = REQ.wdata;
					c_d.wr = REQ.write;
					c_d.kind = KIND_CORE;
				end
			end
			ST_ADDR: begin
				c_d.st = ST_DATA;
			end
			ST_DATA: begin
				c_d.st = ST_IDLE;
				c_d.rsp_valid = 1'b1;
				c_d.rsp.kind = c_q.kind;
				c_d.rsp.data = c_q.wr ? c_q.wdata : D_IN;
				if (c_q.kind == KIND_BOOT) begin
					c_d.evt[EVT_BOOT_BIT] = 1'b1;
				end
			end
			ST_HOLD: begin
				if (!hold_req) begin
					c_d.st = ST_IDLE;
				end
			end
			default: begin
				c_d.st = ST_IDLE;
			end
		endcase

		// New edges are applied after the write and vector clears, so they win over those but lose to reset.
		c_d.ipend = c_d.ipend | (c_q.irq_prev & ~irq_n_s);
		c_d.nmi_pend = c_d.nmi_pend | (c_q.nmi_prev & ~nmi_n_s);

		if (REG_RD) begin
			case (REG_ADDR)
				REG_BANK_CTRL: c_d.reg_rdata = {15'h0000, c_q.keep_en};
				REG_CPU_CTRL: c_d.reg_rdata = {15'h0000, c_q.gdis};
				REG_IRQ_MASK: c_d.reg_rdata = {12'h000, c_q.imask};
				REG_IRQ_PEND: c_d.reg_rdata = {11'h000, c_q.nmi_pend, c_q.ipend};
				REG_EVT_STAT: c_d.reg_rdata = {13'h0000, c_q.evt};
				REG_EVT_MASK: c_d.reg_rdata = {13'h0000, c_q.emask};
				REG_BUS_STAT: c_d.reg_rdata = {6'h00, offline, hold_req, c_q.kind, 1'b0, c_q.st};
				default: c_d.reg_rdata = 16'h0000;
			endcase
		end

		// A low synchronised reset input restarts the state machine and reloads the control, pending and event registers.
		if (!rst_n_s) begin
			c_d.st = ST_RESET;
			c_d.keep_en = KEEPER_RST;
			c_d.gdis = GDIS_RST;
			c_d.imask = IRQ_MASK_RST;
			c_d.ipend = 4'h0;
			c_d.nmi_pend = 1'b0;
			c_d.evt = 3'h0;
			c_d.emask = EVT_MASK_RST;
			c_d.wr = 1'b0;
			c_d.addr = 20'h00000;
			c_d.rsp_valid = 1'b0;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			c_q.st <= ST_RESET;
			c_q.addr <= 20'h00000;
			c_q.wdata <= 16'h0000;
			c_q.wr <= 1'b0;
			c_q.kind <= KIND_CORE;
			c_q.keep_en <= KEEPER_RST;
			c_q.gdis <= GDIS_RST;
			c_q.imask <= IRQ_MASK_RST;
			c_q.ipend <= 4'h0;
			c_q.nmi_pend <= 1'b0;
			c_q.evt <= 3'h0;
			c_q.emask <= EVT_MASK_RST;
			c_q.reg_rdata <= 16'h0000;
			c_q.rsp_valid <= 1'b0;
			c_q.rsp <= '0;
			c_q.irq_prev <= 4'hF;
			c_q.nmi_prev <= 1'b1;
			c_q.last_d <= 16'h0000;
		end else begin
			c_q <= c_d;
		end
	end

	// ==========================================================
	// Pin drivers
	// The data drive is cut at once by hold, reset or offline, even
	// mid-write, because a contending driver would be worse than a lost word.
	assign driving = (c_q.st == ST_ADDR || c_q.st == ST_DATA) && c_q.wr
		&& !hold_req && rst_n_s && !offline;

	assign A_OUT = c_q.addr;
	assign A_OE = (c_q.st != ST_HOLD) && !offline;
	assign D_OUT = c_q.wdata;
	assign D_OE = driving;
	assign D_KEEP_EN = c_q.keep_en && !driving;
	assign D_KEEP_VAL = c_q.last_d;
	assign IRQ_ACK_OUT = (c_q.st == ST_ADDR || c_q.st == ST_DATA) && c_q.kind == KIND_VEC;
	assign IRQ_ACK_OE = !offline;
	assign BUS_RELEASE_ACK = c_q.st == ST_HOLD;
	assign BUS_RELEASE_ACK_OE = !offline;
	assign REQ_READY = c_q.st == ST_IDLE && !hold_req && !c_q.nmi_pend && !irq_any;
	assign RSP_VALID = c_q.rsp_valid;
	assign RSP = c_q.rsp;
	assign REG_RDATA = c_q.reg_rdata;
	assign IRQ_OUT = |(c_q.evt & c_q.emask);
endmodule // xbi_bus_pins
`default_nettype wire

// ===== bench/xbi_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Memory on the far side of the shared bus
module xbi_mem_model (
	input wire logic clk,
	input wire logic drv,
	input wire logic [19:0] a,
	input wire logic a_oe,
	input wire logic [15:0] d_out,
	input wire logic d_oe,
	input wire logic keep_en,
	input wire logic [15:0] keep_val,
	output logic [15:0] d_in
);
	logic [15:0] mem [16];
	logic [15:0] last_q = 16'h0000;
	initial for (int i = 0; i < 16; i++) mem[i] = 16'(16'h1111 * i);
	// An unkept released line flips each cycle, so a stale level never passes for held data.
	always_comb begin
		if (d_oe) d_in = d_out;
		else if (drv && a_oe) d_in = mem[a[3:0]];
		else if (keep_en) d_in = keep_val;
		else d_in = ~last_q;
	end
	always @(posedge clk) begin
		last_q <= d_in;
		if (d_oe) mem[a[3:0]] <= d_out;
	end
endmodule // xbi_mem_model
`default_nettype wire

// ===== bench/xbi_bus_pins_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Pin checks
module xbi_bus_pins_chk
	import xbi_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic OFFLINE_FLOAT_N,
	input wire logic REQ_VALID,
	input wire xbi_pkg::xbi_req_t REQ,
	input wire logic REQ_READY,
	input wire logic RSP_VALID,
	input wire xbi_pkg::xbi_rsp_t RSP,
	input wire logic [19:0] A_OUT,
	input wire logic A_OE,
	input wire logic D_OE,
	input wire logic IRQ_ACK_OUT,
	input wire logic IRQ_ACK_OE,
	input wire logic BUS_RELEASE_ACK,
	input wire logic BUS_RELEASE_ACK_OE
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);
	sequence s_take; REQ_VALID && REQ_READY; endsequence
	sequence s_ack; IRQ_ACK_OUT [*2] ##1 (!IRQ_ACK_OUT && RSP_VALID && RSP.kind == KIND_VEC); endsequence
	property p_hi_addr; s_take ##0 !REQ.prog |=> A_OUT[19:16] == 4'h0; endproperty
	a_hi_addr: assert property (p_hi_addr) else $error("upper address on");
	property p_a_off; !OFFLINE_FLOAT_N |-> !A_OE; endproperty
	a_a_off: assert property (p_a_off) else $error("address driven");
	property p_rsp; s_take |-> ##3 (RSP_VALID && RSP.kind == KIND_CORE); endproperty
	a_rsp: assert property (p_rsp) else $error("no response");
	// Offline floats the data bus even inside a write, so such writes are left out here.
	property p_wr; s_take ##0 (REQ.write && OFFLINE_FLOAT_N) |=> D_OE ##1 D_OE ##1 !D_OE; endproperty
	a_wr: assert property (p_wr) else $error("write drive");
	property p_d_off; !OFFLINE_FLOAT_N |-> !D_OE; endproperty
	a_d_off: assert property (p_d_off) else $error("data driven");
	property p_ack; $rose(IRQ_ACK_OUT) |-> A_OUT[19:7] == 13'h01FF ##0 s_ack; endproperty
	a_ack: assert property (p_ack) else $error("ack cycle");
	property p_ack_off; !OFFLINE_FLOAT_N |-> !IRQ_ACK_OE && !BUS_RELEASE_ACK_OE; endproperty
	a_ack_off: assert property (p_ack_off) else $error("ack driven");
	property p_hold; BUS_RELEASE_ACK |-> !A_OE && !D_OE; endproperty
	a_hold: assert property (p_hold) else $error("hold drive");
endmodule // xbi_bus_pins_chk
bind xbi_bus_pins xbi_bus_pins_chk i_chk (.CLK_SYS, .RST, .OFFLINE_FLOAT_N, .REQ_VALID, .REQ, .REQ_READY,
	.RSP_VALID, .RSP, .A_OUT, .A_OE, .D_OE, .IRQ_ACK_OUT, .IRQ_ACK_OE, .BUS_RELEASE_ACK, .BUS_RELEASE_ACK_OE);
`default_nettype wire

// ===== bench/xbi_bus_pins_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module xbi_bus_pins_tb_top;
	import xbi_pkg::*;
	logic clk = 1'h0, rst = 1'h1, rin_n = 1'h1, nmi_n = 1'h1, hold_n = 1'h1, off_n = 1'h1;
	logic rv = 1'h0, rwr = 1'h0, rrd = 1'h0, drv = 1'h1, rr, sv, irq, a_oe, doe, kep, ack, ack_oe, hk, hk_oe;
	logic [3:0] irq_n = 4'hF, ra = 4'h0;
	logic [15:0] rwd = 16'h0000, rdat, din, dout, kval;
	logic [19:0] a;
	xbi_req_t req = '0;
	xbi_rsp_t rsp;
	int n_fail = 0, compares = 0;
	always #2 clk = ~clk;
	xbi_bus_pins i_dut (.CLK_SYS(clk), .RST(rst), .RESET_IN_N(rin_n), .USER_IRQ_IN_N(irq_n), .NMI_IN_N(nmi_n),
		.HOLD_REQ_N(hold_n), .OFFLINE_FLOAT_N(off_n), .REQ_VALID(rv), .REQ(req), .REQ_READY(rr), .RSP_VALID(sv),
		.RSP(rsp), .REG_ADDR(ra), .REG_WDATA(rwd), .REG_WR(rwr), .REG_RD(rrd), .REG_RDATA(rdat), .IRQ_OUT(irq),
		.A_OUT(a), .A_OE(a_oe), .D_IN(din), .D_OUT(dout), .D_OE(doe), .D_KEEP_EN(kep), .D_KEEP_VAL(kval),
		.IRQ_ACK_OUT(ack), .IRQ_ACK_OE(ack_oe), .BUS_RELEASE_ACK(hk), .BUS_RELEASE_ACK_OE(hk_oe));
	xbi_mem_model i_mem (.clk(clk), .drv(drv), .a(a), .a_oe(a_oe), .d_out(dout), .d_oe(doe), .keep_en(kep),
		.keep_val(kval), .d_in(din));
	// ==========================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] ad, input logic [15:0] d);
		@(posedge clk);
		{rwr, ra, rwd} <= {1'h1, ad, d};
		@(posedge clk);
		rwr <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] ad, input logic [15:0] e, input string nm);
		@(posedge clk);
		{rrd, ra} <= {1'h1, ad};
		@(posedge clk);
		rrd <= 1'h0;
		#1 chk(nm, rdat, e);
	endtask
	task automatic acc(input logic w, input logic p, input logic [19:0] ad, input logic [15:0] wd, e);
		@(posedge clk);
		rv <= 1'h1;
		req <= '{w, p, ad, wd};
		@(posedge clk);
		while (rr !== 1'h1) @(posedge clk);
		rv <= 1'h0;
		tick(2);
		chk("rsp", {sv, rsp.data}, {1'h1, e});
	endtask
	task automatic wait_ack(input logic [19:0] e, input string nm);
		for (int i = 0; i < 12 && ack !== 1'h1; i++) tick(1);
		chk(nm, {ack, a}, {1'h1, e});
	endtask
	task automatic pulse(input logic [3:0] m);
		@(posedge clk);
		irq_n <= ~m;
		repeat (4) @(posedge clk);
		irq_n <= 4'hF;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_boot();
		for (int i = 0; i < 12 && !(sv === 1'h1 && rsp.kind === KIND_BOOT); i++) tick(1);
		chk("boot", {sv, a}, {1'h1, START_ADDR});
		rd(REG_BANK_CTRL, 16'(KEEPER_RST), "keeper");
		rd(REG_CPU_CTRL, 16'(GDIS_RST), "gdis");
		rd(REG_IRQ_MASK, 16'(IRQ_MASK_RST), "imask");
		rd(4'hF, 16'h0000, "unmapped");
		$display("boot done");
	endtask
	task automatic t_bus();
		acc(1'h1, 1'h1, 20'hF0005, 16'hBEEF, 16'hBEEF);
		chk("prog a", a, 20'hF0005);
		acc(1'h0, 1'h1, 20'hF0005, 16'h0000, 16'hBEEF);
		acc(1'h0, 1'h0, 20'h30007, 16'h0000, 16'h7777);
		chk("data a", a, 20'h00007);
		wr(REG_BANK_CTRL, 16'h0001);
		drv <= 1'h0;
		tick(3);
		chk("keeper", {kep, din}, {1'h1, 16'h7777});
		wr(REG_BANK_CTRL, 16'h0000);
		tick(1);
		chk("keeper off", kep, 1'h0);
		$display("bus done");
	endtask
	task automatic t_irq();
		pulse(4'hA);
		rd(REG_IRQ_PEND, 16'h000A, "pend");
		wr(REG_IRQ_PEND, 16'h0008);
		rd(REG_IRQ_PEND, 16'h0002, "pend clr");
		pulse(4'h1);
		wr(REG_CPU_CTRL, 16'h0000);
		tick(8);
		chk("masked", ack, 1'h0);
		wr(REG_IRQ_MASK, 16'h0003);
		wait_ack(20'h0FFC0, "irq0");
		tick(10);
		chk("gdis", ack, 1'h0);
		wr(REG_CPU_CTRL, 16'h0000);
		wait_ack(20'h0FFC4, "irq1");
		tick(4);
		@(posedge clk);
		nmi_n <= 1'h0;
		wait_ack(20'h0FF88, "nmi");
		@(posedge clk);
		nmi_n <= 1'h1;
		wr(REG_EVT_MASK, 16'h0001);
		tick(1);
		chk("irq out", irq, 1'h1);
		wr(REG_EVT_MASK, 16'h0000);
		tick(1);
		chk("irq mask", irq, 1'h0);
		wr(REG_EVT_STAT, 16'h0001);
		wr(REG_EVT_MASK, 16'h0001);
		tick(1);
		chk("irq clr", irq, 1'h0);
		$display("irq done");
	endtask
	task automatic t_pins();
		@(posedge clk);
		off_n <= 1'h0;
		acc(1'h1, 1'h0, 20'h00009, 16'h1234, 16'h1234);
		chk("offline", {a_oe, ack_oe, hk_oe}, 3'h0);
		@(posedge clk);
		{off_n, hold_n} <= 2'h2;
		tick(5);
		chk("hold", {hk, a_oe, doe}, 3'h4);
		@(posedge clk);
		hold_n <= 1'h1;
		wr(REG_BANK_CTRL, 16'h0001);
		@(posedge clk);
		rin_n <= 1'h0;
		tick(4);
		chk("reset d", doe, 1'h0);
		@(posedge clk);
		rin_n <= 1'h1;
		t_boot();
		$display("pins done");
	endtask
	task automatic finish_test();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		t_boot();
		t_bus();
		t_irq();
		t_pins();
		finish_test();
	end
	initial begin
		repeat (2000) @(posedge clk);
		n_fail++;
		finish_test();
	end
endmodule // xbi_bus_pins_tb_top
`default_nettype wire
